// ### design/dsadc_defines.svh
`ifndef DSADC_DEFINES_SVH
`define DSADC_DEFINES_SVH
// Functional notes
// - conversion-done pulse lasts half a clock period
// - latch only after strobe edge before ramp-down
// - polarity comes from the previous conversion
// - multiplexed BCD, blanking between digit selects
// - leading bit 3 low means half digit one
// - leading bit 2 high means positive input
// - bit 0 flags range; bit 3 picks over/under
// - leading bit 1 high for zero half digit
// - one conversion spans a fixed period count
// - clock up to the stated maximum rate
// - internal divider or external clock source

// ****************************************************************
// timing
// ****************************************************************
`define DSADC_ACLK_HZ      32'h05F5E100
`define DSADC_CCLK_MAX_HZ  32'h00061A80
`define DSADC_CONV_TIME_MS 32'h00000028
`define DSADC_CONV_PERIODS 32'h00004010
`define DSADC_HALF_DIV     ((`DSADC_ACLK_HZ + 32'h2 * `DSADC_CCLK_MAX_HZ - 32'h1) / \
                            (32'h2 * `DSADC_CCLK_MAX_HZ))
`define DSADC_CNT_W        15
`define DSADC_DIV_W        8
`define DSADC_SCAN_SLOT    32'h00000040
`define DSADC_SCAN_BLANK   32'h00000004
`define DSADC_SCAN_W       8

// ****************************************************************
// register map and fields
// ****************************************************************
`define DSADC_ADDR_W       8
`define DSADC_OFF_CTRL     8'h00
`define DSADC_OFF_STATUS   8'h04
`define DSADC_OFF_RESULT   8'h08
`define DSADC_OFF_IRQ_STAT 8'h0C
`define DSADC_OFF_IRQ_MASK 8'h10
`define DSADC_CTRL_RUN     0
`define DSADC_CTRL_EXT     1
`define DSADC_RUN_RST      1'h1
`define DSADC_IRQ_W        3
`define DSADC_IRQ_EOC      0
`define DSADC_IRQ_LATCH    1
`define DSADC_IRQ_OOR      2
`define DSADC_RESP_OKAY    2'h0
`define DSADC_RESP_SLVERR  2'h2
`endif

// ### design/dsadc_pkg.sv
`include "dsadc_defines.svh"
package dsadc_pkg;
  typedef enum logic [1:0] {PH_AUTOZERO, PH_INTEGRATE, PH_RAMPDOWN} dsadc_phase_t;

  typedef struct packed {
    logic        half;
    logic [11:0] bcd;
    logic        over;
    logic        under;
    logic        sign;
  } dsadc_result_t;

  typedef struct packed {
    logic [2:0]                  strb_sync;
    logic [1:0]                  ext_sync;
    logic [1:0]                  pol_sync;
    logic [`DSADC_DIV_W-1:0]     div_cnt;
    logic                        cclk_int;
    logic                        cclk_prev;
    logic [`DSADC_CNT_W-1:0]     period_cnt;
    dsadc_phase_t                phase;
    logic                        eoc;
    logic                        armed;
    logic                        pending;
    logic                        pol_cur;
    dsadc_result_t               result;
    logic [15:0]                 digits;
    logic                        run;
    logic                        ext_mode;
    logic [`DSADC_IRQ_W-1:0]     irq_stat;
    logic [`DSADC_IRQ_W-1:0]     irq_mask;
    logic                        aw_held;
    logic [`DSADC_ADDR_W-1:0]    aw_addr;
    logic                        w_held;
    logic [31:0]                 w_data;
    logic [3:0]                  w_strb;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        rvalid;
    logic [1:0]                  rresp;
    logic [31:0]                 rdata;
  } dsadc_top_state_t;

  typedef struct packed {
    logic [1:0]               slot;
    logic [`DSADC_SCAN_W-1:0] cnt;
    logic [3:0]               sel;
    logic [3:0]               bcd;
  } dsadc_scan_state_t;
endpackage

// ### design/dsadc_scan_if.sv
// digit word toward the scanner and the multiplexed outputs back
interface dsadc_scan_if;
  logic [15:0] digits;
  logic [3:0]  digit_sel;
  logic [3:0]  bcd;
  modport producer (output digits, input digit_sel, input bcd);
  modport scanner (input digits, output digit_sel, output bcd);
endinterface

// ### design/dsadc_digit_scan.sv
`include "dsadc_defines.svh"
module dsadc_digit_scan #(
  parameter int SLOT  = `DSADC_SCAN_SLOT,
  parameter int BLANK = `DSADC_SCAN_BLANK
) (
  input  wire logic    aclk,
  input  wire logic    aresetn,
  dsadc_scan_if.scanner scan
);
  localparam int W = `DSADC_SCAN_W;

  if (BLANK < 1 || BLANK >= SLOT || SLOT > (1 << W)) begin : g_bad_scan
    $error("scan slot or blanking out of range");
  end

  dsadc_pkg::dsadc_scan_state_t s_reg;
  dsadc_pkg::dsadc_scan_state_t s_next;

  // ****************************************************************
  // slot sequencing
  // ****************************************************************
  // bcd loads while selects are low, so it never moves under a select
  always_comb begin
    s_next = s_reg;
    if (s_reg.cnt == W'(SLOT - 1)) begin
      s_next.cnt  = '0;
      s_next.slot = s_reg.slot + 2'h1;
    end else begin
      s_next.cnt = s_reg.cnt + W'(1);
    end
    if (s_next.cnt == '0) begin
      case (s_next.slot)
        2'h0:    s_next.bcd = scan.digits[15:12];
        2'h1:    s_next.bcd = scan.digits[11:8];
        2'h2:    s_next.bcd = scan.digits[7:4];
        default: s_next.bcd = scan.digits[3:0];
      endcase
    end
    // interdigit blanking at the head of each slot
    s_next.sel = (s_next.cnt >= W'(BLANK)) ? (4'h1 << s_next.slot) : 4'h0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign scan.digit_sel = s_reg.sel;
  assign scan.bcd       = s_reg.bcd;

  a_one_select: assert property (@(posedge aclk) disable iff (!aresetn)
    $onehot0(s_reg.sel))
    else $error("more than one digit select active");

  a_bcd_steady: assert property (@(posedge aclk) disable iff (!aresetn)
    (|s_reg.sel) && (|$past(s_reg.sel)) |-> $stable(s_reg.bcd))
    else $error("bcd moved while a digit was selected");

  a_sel_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    s_reg.cnt == W'(BLANK) |-> s_reg.sel == (4'h1 << s_reg.slot))
    else $error("select does not match scan slot");
endmodule

// ### design/dsadc_seq_top.sv
`include "dsadc_defines.svh"
module dsadc_seq_top #(
  parameter int CONV_PERIODS = `DSADC_CONV_PERIODS,
  parameter int HALF_DIV     = `DSADC_HALF_DIV,
  parameter int SCAN_SLOT    = `DSADC_SCAN_SLOT,
  parameter int SCAN_BLANK   = `DSADC_SCAN_BLANK
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ext_clk_in,
  input  wire logic        polarity_in,
  input  wire logic        result_latch_strobe,
  input  wire logic        meas_half,
  input  wire logic [11:0] meas_bcd,
  input  wire logic        meas_over,
  input  wire logic        meas_under,
  output wire logic        conv_done,
  output wire logic [3:0]  digit_sel,
  output wire logic [3:0]  bcd_out,
  output wire logic        irq
);
  localparam int CW       = `DSADC_CNT_W;
  localparam int DW       = `DSADC_DIV_W;
  localparam int IW       = `DSADC_IRQ_W;
  localparam int RD_START = CONV_PERIODS / 2;
  localparam int AZ_END   = CONV_PERIODS / 4;

  if (CONV_PERIODS < 8 || CONV_PERIODS > (1 << CW)) begin : g_bad_conv
    $error("conversion period count does not fit the counter");
  end
  if (HALF_DIV < 1 || HALF_DIV >= (1 << DW)) begin : g_bad_div
    $error("half-period divider does not fit the divider");
  end

  dsadc_pkg::dsadc_top_state_t s_reg;
  dsadc_pkg::dsadc_top_state_t s_next;

  logic        cclk;
  logic        tick;
  logic        fall;
  logic        wrap;
  logic        rd_start;
  logic        strb_edge;
  logic        wr_do;
  logic        rd_do;
  logic        rd_clear;
  logic [31:0] rd_word;
  logic [1:0]  rd_resp;
  logic [IW-1:0] irq_set;

  dsadc_scan_if scan_bus ();

  // ****************************************************************
  // leading digit packing
  // ****************************************************************
  // range flags override the half digit in bit 3 and force bit 1 high
  function automatic logic [3:0] lead_code(input dsadc_pkg::dsadc_result_t r);
    logic oor;
    oor          = r.over | r.under;
    lead_code[3] = r.over ? 1'b0 : (r.under ? 1'b1 : ~r.half);
    lead_code[2] = r.sign;
    lead_code[1] = oor | ~r.half;
    lead_code[0] = oor;
  endfunction

  // ****************************************************************
  // converter clock and phase timing
  // ****************************************************************
  // half divider fixes the fastest internal rate; external pin may be slower
  assign cclk = s_reg.ext_mode ? s_reg.ext_sync[1] : s_reg.cclk_int;
  assign tick = cclk & ~s_reg.cclk_prev & s_reg.run;
  assign fall = ~cclk & s_reg.cclk_prev;
  assign wrap = tick && (s_reg.period_cnt == CW'(CONV_PERIODS - 1));
  assign rd_start  = tick && (s_reg.period_cnt == CW'(RD_START - 1));
  assign strb_edge = s_reg.strb_sync[1] & ~s_reg.strb_sync[2];

  // ****************************************************************
  // register bus decode
  // ****************************************************************
  assign s_axi_awready = ~s_reg.aw_held & ~s_reg.bvalid;
  assign s_axi_wready  = ~s_reg.w_held & ~s_reg.bvalid;
  assign s_axi_arready = ~s_reg.rvalid;
  assign wr_do = s_reg.aw_held & s_reg.w_held;
  assign rd_do = s_axi_arvalid & s_axi_arready;
  assign rd_clear = rd_do && (s_axi_araddr == `DSADC_OFF_IRQ_STAT);

  // read mux; unmapped words answer with an error and zero data
  always_comb begin
    rd_word = 32'h0;
    rd_resp = `DSADC_RESP_OKAY;
    case (s_axi_araddr)
      `DSADC_OFF_CTRL: begin
        rd_word[`DSADC_CTRL_RUN] = s_reg.run;
        rd_word[`DSADC_CTRL_EXT] = s_reg.ext_mode;
      end
      `DSADC_OFF_STATUS: begin
        rd_word[1:0] = s_reg.phase;
        rd_word[2]   = s_reg.pol_cur;
        rd_word[3]   = s_reg.armed;
        rd_word[4]   = s_reg.pending;
      end
      `DSADC_OFF_RESULT: begin
        rd_word[11:0] = s_reg.result.bcd;
        rd_word[12]   = s_reg.result.half;
        rd_word[13]   = s_reg.result.sign;
        rd_word[14]   = s_reg.result.over;
        rd_word[15]   = s_reg.result.under;
      end
      `DSADC_OFF_IRQ_STAT: rd_word[IW-1:0] = s_reg.irq_stat;
      `DSADC_OFF_IRQ_MASK: rd_word[IW-1:0] = s_reg.irq_mask;
      default:             rd_resp = `DSADC_RESP_SLVERR;
    endcase
  end

  // events of the conversion that reach the interrupt status
  always_comb begin
    irq_set                   = '0;
    irq_set[`DSADC_IRQ_EOC]   = wrap;
    irq_set[`DSADC_IRQ_LATCH] = wrap & s_reg.pending;
    irq_set[`DSADC_IRQ_OOR]   = wrap & s_reg.pending & (meas_over | meas_under);
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_next = s_reg;
    // strobe, external clock and polarity pins pass two flops before any logic looks at them
    s_next.strb_sync = {s_reg.strb_sync[1:0], result_latch_strobe};
    s_next.ext_sync  = {s_reg.ext_sync[0], ext_clk_in};
    s_next.pol_sync  = {s_reg.pol_sync[0], polarity_in};

    // internal oscillator: toggle every HALF_DIV bus clocks
    if (s_reg.div_cnt == DW'(HALF_DIV - 1)) begin
      s_next.div_cnt  = '0;
      s_next.cclk_int = ~s_reg.cclk_int;
    end else begin
      s_next.div_cnt = s_reg.div_cnt + DW'(1);
    end
    s_next.cclk_prev = cclk;

    // period counter; stopping holds the cycle at its start
    if (!s_reg.run || wrap) begin
      s_next.period_cnt = '0;
    end else if (tick) begin
      s_next.period_cnt = s_reg.period_cnt + CW'(1);
    end
    if (s_next.period_cnt < CW'(AZ_END)) begin
      s_next.phase = dsadc_pkg::PH_AUTOZERO;
    end else if (s_next.period_cnt < CW'(RD_START)) begin
      s_next.phase = dsadc_pkg::PH_INTEGRATE;
    end else begin
      s_next.phase = dsadc_pkg::PH_RAMPDOWN;
    end

    // done pulse rises at the cycle boundary, drops on the next low half
    if (wrap) begin
      s_next.eoc = 1'b1;
    end else if (fall) begin
      s_next.eoc = 1'b0;
    end

    // a strobe edge arms the update; ramp-down start decides it
    // an edge in the deciding cycle still counts, it is not lost
    s_next.armed = (strb_edge | s_reg.armed) & ~rd_start;
    if (rd_start) begin
      s_next.pending = s_reg.armed | strb_edge;
    end

    // cycle end: latch if decided, then adopt the polarity seen meanwhile
    if (wrap) begin
      s_next.pending = 1'b0;
      if (s_reg.pending) begin
        s_next.result.half  = meas_half;
        s_next.result.bcd   = meas_bcd;
        s_next.result.over  = meas_over;
        s_next.result.under = meas_under;
        s_next.result.sign  = s_reg.pol_cur;
      end
      s_next.pol_cur = s_reg.pol_sync[1];
    end
    s_next.digits = {lead_code(s_reg.result), s_reg.result.bcd};

    // sticky status: read clears, a new event in the same cycle wins
    s_next.irq_stat = (s_reg.irq_stat & ~{IW{rd_clear}}) | irq_set;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_held = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (wr_do) begin
      s_next.aw_held = 1'b0;
      s_next.w_held  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = `DSADC_RESP_OKAY;
      case (s_reg.aw_addr)
        `DSADC_OFF_CTRL: begin
          if (s_reg.w_strb[0]) begin
            s_next.run      = s_reg.w_data[`DSADC_CTRL_RUN];
            s_next.ext_mode = s_reg.w_data[`DSADC_CTRL_EXT];
          end
        end
        `DSADC_OFF_IRQ_MASK: begin
          if (s_reg.w_strb[0]) begin
            s_next.irq_mask = s_reg.w_data[IW-1:0];
          end
        end
        `DSADC_OFF_STATUS, `DSADC_OFF_RESULT, `DSADC_OFF_IRQ_STAT: begin
          s_next.bresp = `DSADC_RESP_OKAY;
        end
        default: s_next.bresp = `DSADC_RESP_SLVERR;
      endcase
    end else if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    // read channel: one cycle from address to data
    if (rd_do) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = rd_word;
      s_next.rresp  = rd_resp;
    end else if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg     <= '0;
      s_reg.run <= `DSADC_RUN_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // outputs and digit scanner
  // ****************************************************************
  assign scan_bus.digits = s_reg.digits;

  dsadc_digit_scan #(
    .SLOT  (SCAN_SLOT),
    .BLANK (SCAN_BLANK)
  ) u_scan (
    .aclk    (aclk),
    .aresetn (aresetn),
    .scan    (scan_bus.scanner)
  );

  assign digit_sel     = scan_bus.digit_sel;
  assign bcd_out       = scan_bus.bcd;
  assign conv_done     = s_reg.eoc;
  assign irq           = |(s_reg.irq_stat & s_reg.irq_mask);
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rdata   = s_reg.rdata;
  assign s_axi_rresp   = s_reg.rresp;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // helper: length of the done pulse in bus clocks
  logic [DW-1:0] eoc_len;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eoc_len <= '0;
    end else begin
      eoc_len <= s_reg.eoc ? eoc_len + DW'(1) : '0;
    end
  end

  a_eoc_half_period: assert property (
    $fell(s_reg.eoc) && !s_reg.ext_mode && $past(s_reg.run) |-> eoc_len == DW'(HALF_DIV))
    else $error("done pulse is not half a converter period");

  a_conv_wrap: assert property (
    wrap |=> s_reg.period_cnt == '0 && s_reg.eoc)
    else $error("cycle did not restart after the last period");

  a_cnt_bound: assert property (
    s_reg.period_cnt < CW'(CONV_PERIODS))
    else $error("period counter beyond conversion length");

  a_latch_skip: assert property (
    wrap && !s_reg.pending |=> $stable(s_reg.result))
    else $error("result changed without a strobe edge");

  a_latch_take: assert property (
    wrap && s_reg.pending |=> s_reg.result.bcd == $past(meas_bcd))
    else $error("armed conversion did not latch its result");

  a_sign_prev: assert property (
    wrap && s_reg.pending |=> s_reg.result.sign == $past(s_reg.pol_cur))
    else $error("result sign not from previous polarity");

  a_lead_half: assert property (
    !s_reg.result.over && !s_reg.result.under |=>
      s_reg.digits[15] == !$past(s_reg.result.half))
    else $error("half digit bit coded wrongly");

  a_lead_sign: assert property (
    1'b1 |=> s_reg.digits[14] == $past(s_reg.result.sign))
    else $error("sign bit coded wrongly");

  a_lead_range: assert property (
    s_reg.result.over |=> s_reg.digits[12] && !s_reg.digits[15])
    else $error("over-range not flagged in the leading digit");

  a_lead_bit1: assert property (
    !s_reg.result.over && !s_reg.result.under |=>
      s_reg.digits[13] == !$past(s_reg.result.half))
    else $error("leading bit 1 coded wrongly");
endmodule

// ### verification/dsadc_host_model.sv
// ********
// host side: strobe and digit capture
// ********
module dsadc_host_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        en,
  input  wire logic        conv_done,
  input  wire logic [3:0]  digit_sel,
  input  wire logic [3:0]  bcd_out,
  output logic             strobe,
  output logic [15:0]      dig,
  output logic             scan_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] last;
  logic [3:0] psel;
  logic [3:0] pbcd;

  // strobe drops in the pulse and rises after it, one edge per read cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe   <= 1'h0;
      dig      <= 16'h0000;
      scan_err <= 1'h0;
      last     <= 4'h8;
      psel     <= 4'h0;
      pbcd     <= 4'h0;
    end else begin
      strobe <= en & ~conv_done;
      psel   <= digit_sel;
      pbcd   <= bcd_out;
      if (digit_sel != 4'h0) begin
        for (int i = 0; i < 4; i++) if (digit_sel[i]) dig[4*i+:4] <= bcd_out;
        if (!$onehot(digit_sel)) scan_err <= 1'h1;
        if (digit_sel == psel && bcd_out != pbcd) scan_err <= 1'h1;
        // a new slot must be the next position after the last one seen
        if (digit_sel != psel && digit_sel != {last[2:0], last[3]}) scan_err <= 1'h1;
        last <= digit_sel;
      end
    end
  end
endmodule

// ### verification/tb.sv
`include "dsadc_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV  = 64;
  localparam int HDIV  = 2;
  localparam int LIMIT = 20000;
  localparam logic [15:0] CASES [4] = '{16'h2123, 16'h3999, 16'h7999, 16'hA000};
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, ext_clk_in, polarity_in, result_latch_strobe;
  logic        meas_half, meas_over, meas_under, conv_done, irq, host_en, ext_on, scan_err;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb, digit_sel, bcd_out;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [11:0] meas_bcd;
  logic [15:0] dig;
  logic        host_strobe, tie_on;
  int          error_cnt, n_checks, cyc, t0;

  dsadc_seq_top #(.CONV_PERIODS(CONV), .HALF_DIV(HDIV), .SCAN_SLOT(8), .SCAN_BLANK(2)) DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_clk_in, .polarity_in,
    .result_latch_strobe, .meas_half, .meas_bcd, .meas_over, .meas_under,
    .conv_done, .digit_sel, .bcd_out, .irq
  );

  dsadc_host_model host (
    .aclk, .aresetn, .en(host_en), .conv_done, .digit_sel, .bcd_out,
    .strobe(host_strobe), .dig, .scan_err
  );

  // standalone wiring feeds the done pulse straight back as the strobe
  assign result_latch_strobe = tie_on ? conv_done : host_strobe;

  // ********
  // clock, external converter clock, watchdog
  // ********
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  // external clock period is six aclk cycles, held low while unused
  initial begin
    ext_clk_in = 1'h0;
    forever begin
      repeat (3) @(posedge aclk);
      ext_clk_in <= ext_on & ~ext_clk_in;
    end
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ********
  // tasks
  // ********
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // returns at the first edge that sees a fresh pulse
  task automatic wait_eoc();
    while (conv_done === 1'h1) @(posedge aclk);
    while (conv_done !== 1'h1) @(posedge aclk);
  endtask

  task automatic set_meas(input logic [15:0] c);
    meas_bcd   <= c[11:0];
    meas_half  <= c[12];
    meas_over  <= c[14];
    meas_under <= c[15];
  endtask

  // packed leading digit, worked out from half, sign and range flags
  function automatic logic [3:0] lead(input logic [15:0] c);
    return {c[14] ? 1'h0 : (c[15] | ~c[12]), c[13], c[14] | c[15] | ~c[12], c[14] | c[15]};
  endfunction

  // ********
  // test sequence
  // ********
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {host_en, ext_on, tie_on, cyc, error_cnt, n_checks} = 0;
    s_axi_wstrb = 4'hF;
    polarity_in = 1'h1;
    set_meas(16'h0000);
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`DSADC_OFF_CTRL);
    chk("ctrl reset", 32'h00000001, rv);
    rd(`DSADC_OFF_IRQ_MASK);
    chk("mask reset", 32'h00000000, rv);
    rd(`DSADC_OFF_RESULT);
    chk("result reset", 32'h00000000, rv);
    rd(8'h14);
    chk("unmapped rresp", `DSADC_RESP_SLVERR, rsp);
    chk("unmapped rdata", 32'h00000000, rv);
    wr(8'h14, 32'hFFFFFFFF);
    chk("unmapped bresp", `DSADC_RESP_SLVERR, rsp);
    $display("test reset done");

    wait_eoc();
    t0 = cyc;
    rv = 32'h0;
    while (conv_done === 1'h1) begin
      @(posedge aclk);
      rv++;
    end
    chk("eoc width", HDIV, rv);
    wait_eoc();
    chk("conv period", CONV * 2 * HDIV, cyc - t0);
    $display("test timing done");

    // two conversions per case so sign and strobe have settled
    host_en <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      set_meas(CASES[i]);
      wait_eoc();
      wait_eoc();
      rd(`DSADC_OFF_RESULT);
      chk("result", CASES[i], rv);
      repeat (80) @(posedge aclk);
      chk("digits", {CASES[i][3:0], CASES[i][7:4], CASES[i][11:8], lead(CASES[i])}, dig);
    end
    $display("test coding done");

    host_en <= 1'h0;
    wait_eoc();
    rd(`DSADC_OFF_IRQ_STAT);
    set_meas(CASES[0]);
    wait_eoc();
    repeat (2) @(posedge aclk);
    chk("irq masked", 32'h0, irq);
    rd(`DSADC_OFF_IRQ_STAT);
    chk("irq stat", 32'h1, rv & 32'h3);
    rd(`DSADC_OFF_RESULT);
    chk("result held", CASES[3], rv);
    $display("test no strobe done");

    // the first result after the polarity flips still carries the old sign
    host_en <= 1'h1;
    polarity_in <= 1'h0;
    wait_eoc();
    rd(`DSADC_OFF_RESULT);
    chk("old sign", 32'h2123, rv);
    rd(`DSADC_OFF_STATUS);
    chk("status", 32'h00000000, rv & 32'h00000007);
    wait_eoc();
    rd(`DSADC_OFF_RESULT);
    chk("new sign", 32'h0123, rv);
    $display("test polarity done");

    wr(`DSADC_OFF_IRQ_MASK, 32'h1);
    rd(`DSADC_OFF_IRQ_STAT);
    wait_eoc();
    repeat (2) @(posedge aclk);
    chk("irq high", 32'h1, irq);
    rd(`DSADC_OFF_IRQ_STAT);
    chk("stat eoc", 32'h3, rv & 32'h3);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 32'h0, irq);
    $display("test irq done");

    // strobe tied to the done pulse, host idle
    host_en <= 1'h0;
    tie_on  <= 1'h1;
    set_meas(CASES[1]);
    wait_eoc();
    wait_eoc();
    rd(`DSADC_OFF_RESULT);
    chk("tied strobe", 32'h00001999, rv);
    $display("test tied strobe done");

    wr(`DSADC_OFF_CTRL, 32'h3);
    ext_on <= 1'h1;
    wait_eoc();
    wait_eoc();
    t0 = cyc;
    wait_eoc();
    chk("ext period", CONV * 6, cyc - t0);
    chk("scan order", 32'h0, scan_err);
    $display("test ext clock done");
    tally_and_finish();
  end
endmodule
